// ---- hdl/tib_bridge_regs.svh ----
// constant values for the triplicated expander to i/o bridge replica
`ifndef TIB_BRIDGE_REGS_SVH
`define TIB_BRIDGE_REGS_SVH

// ---------------------------------------------------------------
// link packet framing
// ---------------------------------------------------------------
`define TIB_CMD_LAST    5'd20
`define TIB_RSP_LAST    5'd31

// ---------------------------------------------------------------
// chassis address range
// ---------------------------------------------------------------
`define TIB_ADDR_MIN    4'h2
`define TIB_ADDR_MAX    4'h8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TIB_CLK_NS      4
`define TIB_SHR_BIT_NS  16
`define TIB_IO_TMO_NS   1000
`define TIB_SHR_TMO_NS  2000
`define TIB_SHR_BIT_CYC ((`TIB_SHR_BIT_NS + `TIB_CLK_NS - 1) / `TIB_CLK_NS)
`define TIB_SHR_FIRST   (`TIB_SHR_BIT_CYC + `TIB_SHR_BIT_CYC / 2 - 1)
`define TIB_IO_TMO_CYC  (`TIB_IO_TMO_NS / `TIB_CLK_NS)
`define TIB_SHR_TMO_CYC (`TIB_SHR_TMO_NS / `TIB_CLK_NS)
`define TIB_SHR_FRAME   4'd10

`endif

// ---- hdl/tib_pkg.sv ----
// types shared by the bridge replica
`default_nettype none
package tib_pkg;

	// command packet as shifted in, first bit is the msb
	typedef struct packed {
		logic [3:0] chassis_id;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tib_cmd_t;

	// command plus the slot lines captured with it
	typedef struct packed {
		tib_cmd_t   cmd;
		logic [3:0] slot;
	} tib_req_t;

	// response packet, diagnostics first, then replica a, b, c
	typedef struct packed {
		logic [7:0] diag;
		logic [7:0] data_a;
		logic [7:0] data_b;
		logic [7:0] data_c;
	} tib_rsp_t;

	typedef enum logic [1:0] {
		TIB_IDLE,
		TIB_ACCESS,
		TIB_SHARE,
		TIB_QUEUE
	} tib_state_t;

endpackage : tib_pkg
`default_nettype wire

// ---- hdl/tib_bridge.sv ----
// one replica of the triplicated expander link to i/o bridge
`include "tib_bridge_regs.svh"
`default_nettype none

// What this block does
// - replicas order responses identically, sent together
// - response bits clocked by received link clock
// - reads share own i/o data with peers
// - read response holds three data sets sequentially
// - writes never touch the share link
// - decode command, access module, send response
// - every response carries data and diagnostics
// - packet carries four bit chassis identifier
// - straps 0..3 weigh 1, 2, 4, 8
// - removed strap reads as a one
// - chassis address valid from 2 to 8
module tib_bridge (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       lnk_clk,
	input  wire logic       lnk_en,
	input  wire logic       lnk_dir,
	input  wire logic       lnk_data_in,
	output var  logic       lnk_data_out,
	output var  logic       lnk_data_oe,
	input  wire logic [3:0] lnk_slot,
	input  wire logic [3:0] chassis_address_strap,
	input  wire logic [1:0] replica_index,
	output var  logic       io_req,
	output var  logic       io_wr,
	output var  logic [3:0] io_slot,
	output var  logic [7:0] io_addr,
	output var  logic [7:0] io_wdata,
	input  wire logic [7:0] io_rdata,
	input  wire logic       io_ack,
	output var  logic       replica_share_link_tx,
	input  wire logic [1:0] replica_share_link_rx
);
	import tib_pkg::*;

	// ---------------------------------------------------------------
	// link domain
	// ---------------------------------------------------------------
	logic       lrst_s1_reg, lrst_reg;
	logic       rsp_tgl_s1_reg, rsp_tgl_s2_reg;
	logic [20:0] rx_sh_reg, rx_sh_next;
	logic [4:0] rx_cnt_reg, rx_cnt_next;
	tib_req_t   cmd_hold_reg, cmd_hold_next;
	logic       cmd_tgl_reg, cmd_tgl_next;
	tib_rsp_t   rsp_hold_reg, rsp_hold_next;
	logic [31:0] tx_sh_reg, tx_sh_next;
	logic [4:0] tx_cnt_reg, tx_cnt_next;
	logic       tx_busy_reg, tx_busy_next;
	logic       ack_tgl_reg, ack_tgl_next;
	logic       rsp_tgl_reg, rsp_tgl_next;
	logic       out_reg, out_next;
	logic       oe_reg, oe_next;

	// reset and response toggle into the link clock
	always_ff @(posedge lnk_clk)
	begin
		lrst_s1_reg    <= reset;
		lrst_reg       <= lrst_s1_reg;
		rsp_tgl_s1_reg <= rsp_tgl_reg;
		rsp_tgl_s2_reg <= rsp_tgl_s1_reg;
	end

	// command shift in, one bit per link clock while receiving
	always_comb
	begin
		rx_sh_next    = rx_sh_reg;
		rx_cnt_next   = rx_cnt_reg;
		cmd_hold_next = cmd_hold_reg;
		cmd_tgl_next  = cmd_tgl_reg;
		if (!lnk_en)
			rx_cnt_next = 5'd0;
		else if (!lnk_dir)
		begin
			rx_sh_next = {rx_sh_reg[19:0], lnk_data_in};
			if (rx_cnt_reg == `TIB_CMD_LAST)
			begin
				cmd_hold_next.cmd  = tib_cmd_t'(rx_sh_next);
				cmd_hold_next.slot = lnk_slot;
				cmd_tgl_next       = ~cmd_tgl_reg;
				rx_cnt_next        = 5'd0;
			end
			else
				rx_cnt_next = rx_cnt_reg + 5'd1;
		end
	end

	// response shift out on the received clock edge
	always_comb
	begin
		tx_sh_next   = tx_sh_reg;
		tx_cnt_next  = tx_cnt_reg;
		tx_busy_next = tx_busy_reg;
		ack_tgl_next = ack_tgl_reg;
		out_next     = out_reg;
		oe_next      = 1'b0;
		if (!tx_busy_reg && (rsp_tgl_s2_reg != ack_tgl_reg))
		begin
			tx_sh_next   = rsp_hold_reg;
			tx_cnt_next  = 5'd0;
			tx_busy_next = 1'b1;
			ack_tgl_next = ~ack_tgl_reg;
		end
		else if (tx_busy_reg && lnk_en && lnk_dir)
		begin
			out_next   = tx_sh_reg[31];
			oe_next    = 1'b1;
			tx_sh_next = {tx_sh_reg[30:0], 1'b0};
			if (tx_cnt_reg == `TIB_RSP_LAST)
				tx_busy_next = 1'b0;
			else
				tx_cnt_next = tx_cnt_reg + 5'd1;
		end
	end

	always_ff @(posedge lnk_clk)
	begin
		if (lrst_reg)
		begin
			rx_sh_reg    <= '0;
			rx_cnt_reg   <= '0;
			cmd_hold_reg <= '0;
			cmd_tgl_reg  <= 1'b0;
			tx_sh_reg    <= '0;
			tx_cnt_reg   <= '0;
			tx_busy_reg  <= 1'b0;
			ack_tgl_reg  <= 1'b0;
			out_reg      <= 1'b0;
			oe_reg       <= 1'b0;
		end
		else
		begin
			rx_sh_reg    <= rx_sh_next;
			rx_cnt_reg   <= rx_cnt_next;
			cmd_hold_reg <= cmd_hold_next;
			cmd_tgl_reg  <= cmd_tgl_next;
			tx_sh_reg    <= tx_sh_next;
			tx_cnt_reg   <= tx_cnt_next;
			tx_busy_reg  <= tx_busy_next;
			ack_tgl_reg  <= ack_tgl_next;
			out_reg      <= out_next;
			oe_reg       <= oe_next;
		end
	end

	assign lnk_data_out = out_reg;
	assign lnk_data_oe  = oe_reg;

	// ---------------------------------------------------------------
	// pin inputs and crossings into the core clock
	// ---------------------------------------------------------------
	logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic [7:0] pin_reg, pin_next;
	logic       cmd_s1_reg, cmd_s2_reg;
	logic       ack_s1_reg, ack_s2_reg;

	always_ff @(posedge clk)
	begin
		pin_s1_reg <= {replica_share_link_rx, replica_index, chassis_address_strap};
		pin_s2_reg <= pin_s1_reg;
		pin_s3_reg <= pin_s2_reg;
		cmd_s1_reg <= cmd_tgl_reg;
		cmd_s2_reg <= cmd_s1_reg;
		ack_s1_reg <= ack_tgl_reg;
		ack_s2_reg <= ack_s1_reg;
	end

	// a bit changes only when the second and third stage agree
	always_comb
	begin
		pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
			| (pin_reg & (pin_s2_reg ^ pin_s3_reg));
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pin_reg <= 8'hff;
		else
			pin_reg <= pin_next;
	end

	logic [3:0] chassis_addr;
	logic       addr_ok;
	logic [1:0] own_idx;
	assign chassis_addr = pin_reg[3:0];
	assign addr_ok = (chassis_addr >= `TIB_ADDR_MIN)
		&& (chassis_addr <= `TIB_ADDR_MAX);
	assign own_idx = (pin_reg[5:4] == 2'd3) ? 2'd0 : pin_reg[5:4];

	// ---------------------------------------------------------------
	// share link receivers, one per peer
	// ---------------------------------------------------------------
	logic [1:0] rx_done;
	logic [7:0] rx_byte [2];
	logic       rx_clr;

	for (genvar g = 0; g < 2; g++)
	begin : peer
		logic       act_reg, act_next;
		logic [3:0] tmr_reg, tmr_next;
		logic [3:0] bits_reg, bits_next;
		logic [7:0] data_reg, data_next;
		logic       done_reg, done_next;
		logic       set;

		// start bit, eight bits mid bit lsb first, then wait to the middle of the stop bit
		always_comb
		begin
			act_next  = act_reg;
			tmr_next  = tmr_reg;
			bits_next = bits_reg;
			data_next = data_reg;
			set       = 1'b0;
			if (!act_reg)
			begin
				if (!pin_reg[6 + g])
				begin
					act_next  = 1'b1;
					tmr_next  = 4'(`TIB_SHR_FIRST);
					bits_next = 4'd0;
				end
			end
			else if (tmr_reg == 4'd0)
			begin
				tmr_next  = 4'(`TIB_SHR_BIT_CYC - 1);
				bits_next = bits_reg + 4'd1;
				// re-arming on a low last data bit would start a false frame
				if (bits_reg == 4'd8)
					act_next = 1'b0;
				else
				begin
					data_next = {pin_reg[6 + g], data_reg[7:1]};
					set       = (bits_reg == 4'd7);
				end
			end
			else
				tmr_next = tmr_reg - 4'd1;
			done_next = (done_reg & ~rx_clr) | set;    // set wins
		end

		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				act_reg  <= 1'b0;
				tmr_reg  <= '0;
				bits_reg <= '0;
				data_reg <= '0;
				done_reg <= 1'b0;
			end
			else
			begin
				act_reg  <= act_next;
				tmr_reg  <= tmr_next;
				bits_reg <= bits_next;
				data_reg <= data_next;
				done_reg <= done_next;
			end
		end

		assign rx_done[g] = done_reg;
		assign rx_byte[g] = data_reg;
	end

	// ---------------------------------------------------------------
	// core sequencer
	// ---------------------------------------------------------------
	tib_state_t  state_reg, state_next;
	logic        seen_reg, seen_next;
	tib_req_t    req_reg, req_next;
	logic        io_req_reg, io_req_next;
	logic [7:0]  own_reg, own_next;
	logic        tmo_reg, tmo_next;
	logic [9:0]  tmr_reg, tmr_next;
	logic [9:0]  shr_sh_reg, shr_sh_next;
	logic [3:0]  shr_left_reg, shr_left_next;
	logic [3:0]  shr_tmr_reg, shr_tmr_next;
	logic        push;
	logic        fifo_full;
	tib_rsp_t    rsp;
	logic [7:0]  slot_data [3];
	logic [1:0]  idx_p0, idx_p1;

	assign idx_p0 = (own_idx == 2'd2) ? 2'd0 : own_idx + 2'd1;
	assign idx_p1 = (idx_p0 == 2'd2) ? 2'd0 : idx_p0 + 2'd1;

	// data sets placed by replica index, same order in every replica
	always_comb
	begin
		slot_data[0] = 8'h00;
		slot_data[1] = 8'h00;
		slot_data[2] = 8'h00;
		if (!req_reg.cmd.wr)
		begin
			slot_data[own_idx] = own_reg;
			slot_data[idx_p0]  = rx_byte[0];
			slot_data[idx_p1]  = rx_byte[1];
		end
		rsp.diag   = {chassis_addr, 1'b0,
			req_reg.cmd.wr ? 2'b00 : ~rx_done, tmo_reg};
		rsp.data_a = slot_data[0];
		rsp.data_b = slot_data[1];
		rsp.data_c = slot_data[2];
	end

	always_comb
	begin
		state_next    = state_reg;
		seen_next     = seen_reg;
		req_next      = req_reg;
		io_req_next   = io_req_reg;
		own_next      = own_reg;
		tmo_next      = tmo_reg;
		tmr_next      = tmr_reg + 10'd1;
		shr_sh_next   = shr_sh_reg;
		shr_left_next = shr_left_reg;
		shr_tmr_next  = shr_tmr_reg;
		rx_clr        = 1'b0;
		push          = 1'b0;
		// share transmitter paces one bit per bit period
		if (shr_left_reg != 4'd0)
		begin
			if (shr_tmr_reg == 4'd0)
			begin
				shr_sh_next   = {1'b1, shr_sh_reg[9:1]};
				shr_left_next = shr_left_reg - 4'd1;
				shr_tmr_next  = 4'(`TIB_SHR_BIT_CYC - 1);
			end
			else
				shr_tmr_next = shr_tmr_reg - 4'd1;
		end
		case (state_reg)
			TIB_IDLE:
			begin
				if (cmd_s2_reg != seen_reg)
				begin
					seen_next = cmd_s2_reg;
					req_next  = cmd_hold_reg;
					if (addr_ok && (cmd_hold_reg.cmd.chassis_id == chassis_addr))
					begin
						state_next  = TIB_ACCESS;
						io_req_next = 1'b1;
						tmo_next    = 1'b0;
						tmr_next    = 10'd0;
						rx_clr      = 1'b1;
					end
				end
			end
			TIB_ACCESS:
			begin
				if (io_ack || (tmr_reg == 10'(`TIB_IO_TMO_CYC)))
				begin
					io_req_next = 1'b0;
					tmo_next    = !io_ack;
					own_next    = io_ack ? io_rdata : 8'h00;
					tmr_next    = 10'd0;
					if (req_reg.cmd.wr)
						state_next = TIB_QUEUE;
					else
					begin
						state_next    = TIB_SHARE;
						shr_sh_next   = {1'b1, io_ack ? io_rdata : 8'h00, 1'b0};
						shr_left_next = `TIB_SHR_FRAME;
						shr_tmr_next  = 4'(`TIB_SHR_BIT_CYC - 1);
					end
				end
			end
			TIB_SHARE:
			begin
				if ((shr_left_reg == 4'd0) && ((rx_done == 2'b11)
					|| (tmr_reg == 10'(`TIB_SHR_TMO_CYC))))
					state_next = TIB_QUEUE;
			end
			TIB_QUEUE:
			begin
				if (!fifo_full)
				begin
					push       = 1'b1;
					state_next = TIB_IDLE;
				end
			end
			default: state_next = TIB_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_reg    <= TIB_IDLE;
			seen_reg     <= 1'b0;
			req_reg      <= '0;
			io_req_reg   <= 1'b0;
			own_reg      <= '0;
			tmo_reg      <= 1'b0;
			tmr_reg      <= '0;
			shr_sh_reg   <= 10'h3ff;
			shr_left_reg <= '0;
			shr_tmr_reg  <= '0;
		end
		else
		begin
			state_reg    <= state_next;
			seen_reg     <= seen_next;
			req_reg      <= req_next;
			io_req_reg   <= io_req_next;
			own_reg      <= own_next;
			tmo_reg      <= tmo_next;
			tmr_reg      <= tmr_next;
			shr_sh_reg   <= shr_sh_next;
			shr_left_reg <= shr_left_next;
			shr_tmr_reg  <= shr_tmr_next;
		end
	end

	assign io_req   = io_req_reg;
	assign io_wr    = req_reg.cmd.wr;
	assign io_slot  = req_reg.slot;
	assign io_addr  = req_reg.cmd.addr;
	assign io_wdata = req_reg.cmd.wdata;
	assign replica_share_link_tx = shr_sh_reg[0];

	// ---------------------------------------------------------------
	// two entry response buffer and hand over to the link clock
	// ---------------------------------------------------------------
	tib_rsp_t   fifo_mem [2];
	logic [1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic       rsp_busy_reg, rsp_busy_next;
	logic       fifo_empty;

	assign fifo_full  = (wp_reg ^ rp_reg) == 2'b10;
	assign fifo_empty = wp_reg == rp_reg;

	always_comb
	begin
		wp_next       = push ? wp_reg + 2'd1 : wp_reg;
		rp_next       = rp_reg;
		rsp_tgl_next  = rsp_tgl_reg;
		rsp_busy_next = rsp_busy_reg;
		rsp_hold_next = rsp_hold_reg;
		if (rsp_busy_reg && (ack_s2_reg == rsp_tgl_reg))
			rsp_busy_next = 1'b0;
		else if (!rsp_busy_reg && !fifo_empty)
		begin
			rsp_hold_next = fifo_mem[rp_reg[0]];
			rp_next       = rp_reg + 2'd1;
			rsp_tgl_next  = ~rsp_tgl_reg;
			rsp_busy_next = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			fifo_mem[wp_reg[0]] <= rsp;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wp_reg       <= '0;
			rp_reg       <= '0;
			rsp_tgl_reg  <= 1'b0;
			rsp_busy_reg <= 1'b0;
			rsp_hold_reg <= '0;
		end
		else
		begin
			wp_reg       <= wp_next;
			rp_reg       <= rp_next;
			rsp_tgl_reg  <= rsp_tgl_next;
			rsp_busy_reg <= rsp_busy_next;
			rsp_hold_reg <= rsp_hold_next;
		end
	end

endmodule : tib_bridge
`default_nettype wire

// ---- tb/tib_bridge_sva.sv ----
// concurrent checks on the ports of one bridge replica
`default_nettype none
module tib_bridge_sva (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       lnk_clk,
	input wire logic       lnk_en,
	input wire logic       lnk_dir,
	input wire logic       lnk_data_oe,
	input wire logic [3:0] chassis_address_strap,
	input wire logic       io_req,
	input wire logic       io_wr,
	input wire logic [3:0] io_slot,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_ack,
	input wire logic       replica_share_link_tx
);
	// ---------------------------------------------
	// i/o access
	// ---------------------------------------------
	property p_ack_drop;
		@(posedge clk) disable iff (reset) io_req && io_ack |=> !io_req;
	endproperty
	a_ack_drop: assert property (p_ack_drop)
		else $error("io_req still high after ack");
	property p_req_bound;
		@(posedge clk) disable iff (reset) $rose(io_req) |-> ##[1:260] !io_req;
	endproperty
	a_req_bound: assert property (p_req_bound)
		else $error("io access outlived its timeout");
	property p_fields_hold;
		@(posedge clk) disable iff (reset)
			io_req && $past(io_req) |-> $stable({io_wr, io_slot, io_addr, io_wdata});
	endproperty
	a_fields_hold: assert property (p_fields_hold)
		else $error("access fields moved during access");
	property p_strap_range;
		@(posedge clk) disable iff (reset)
			$rose(io_req) |-> chassis_address_strap inside {[4'h2:4'h8]};
	endproperty
	a_strap_range: assert property (p_strap_range)
		else $error("access with chassis address out of range");
	property p_no_oe_access;
		@(posedge clk) disable iff (reset) io_req |-> !lnk_data_oe;
	endproperty
	a_no_oe_access: assert property (p_no_oe_access)
		else $error("response driven during i/o access");
	// ---------------------------------------------
	// share link and response line
	// ---------------------------------------------
	property p_wr_quiet;
		@(posedge clk) disable iff (reset) $fell(replica_share_link_tx) |-> !io_wr;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet)
		else $error("share frame started for a write");
	property p_tx_start;
		@(posedge clk) disable iff (reset)
			$fell(replica_share_link_tx) |-> !replica_share_link_tx [*4];
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("share start bit shorter than four cycles");
	property p_oe_dir;
		@(posedge lnk_clk) disable iff (reset) !(lnk_en && lnk_dir) |=> !lnk_data_oe;
	endproperty
	a_oe_dir: assert property (p_oe_dir)
		else $error("data line driven without enable and direction");
endmodule : tib_bridge_sva

bind tib_bridge tib_bridge_sva i_sva (.clk(clk), .reset(reset), .lnk_clk(lnk_clk),
	.lnk_en(lnk_en), .lnk_dir(lnk_dir), .lnk_data_oe(lnk_data_oe), .io_req(io_req),
	.chassis_address_strap(chassis_address_strap), .io_wr(io_wr), .io_slot(io_slot),
	.io_addr(io_addr), .io_wdata(io_wdata), .io_ack(io_ack),
	.replica_share_link_tx(replica_share_link_tx));
`default_nettype wire

// ---- tb/tib_expander_model.sv ----
// expander side model: link clock, command frames, response capture
`default_nettype none
module tib_expander_model (
	output var logic       lnk_clk,
	output var logic       lnk_en,
	output var logic       lnk_dir,
	output var logic       lnk_data_in,
	output var logic [3:0] lnk_slot,
	input  wire logic      lnk_data_out,
	input  wire logic      lnk_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	import tib_pkg::*;

	// idle link, clock stands still
	initial
	begin
		lnk_clk = 1'b0;
		lnk_en = 1'b0;
		lnk_dir = 1'b0;
		lnk_data_in = 1'b0;
		lnk_slot = 4'h0;
	end

	// one 32 ns link clock, inputs move just after the fall
	task automatic tick();
		#15 lnk_clk = 1'b1;
		#16 lnk_clk = 1'b0;
		#1;
	endtask : tick

	// command frame, msb first, slot held over the frame
	task automatic send_cmd(input tib_cmd_t c, input logic [3:0] s);
		lnk_en = 1'b1;
		lnk_dir = 1'b0;
		lnk_slot = s;
		for (int i = 20; i >= 0; i--)
		begin
			lnk_data_in = c[i];
			tick();
		end
		lnk_en = 1'b0;
		lnk_data_in = ~lnk_data_in; // released line no longer shows the last bit
		lnk_slot = ~s;
	endtask : send_cmd

	// clock the answer in, count driven bits, flag a line held too long
	task automatic get_rsp(input int lim, output tib_rsp_t r, output int nb);
		nb = 0;
		r = '0;
		lnk_en = 1'b1;
		lnk_dir = 1'b1;
		for (int i = 0; i < lim && nb < 32; i++)
		begin
			tick();
			lnk_data_in = ~lnk_data_in;
			if (lnk_data_oe === 1'b1)
			begin
				r = {r[30:0], lnk_data_out};
				nb++;
			end
		end
		tick();
		if (lnk_data_oe !== 1'b0)
			nb = -1;
		lnk_en = 1'b0;
		lnk_dir = 1'b0;
	endtask : get_rsp
endmodule : tib_expander_model
`default_nettype wire

// ---- tb/tb_tib_bridge.sv ----
// self-checking bench for one bridge replica
`default_nettype none
module tb_tib_bridge;
	timeunit 1ns;
	timeprecision 1ps;
	import tib_pkg::*;

	logic        clk, reset, io_ack, lnk_clk, lnk_en, lnk_dir, lnk_data_in;
	logic        lnk_data_out, lnk_data_oe, io_req, io_wr, tx;
	logic [3:0]  lnk_slot, strap, io_slot;
	logic [7:0]  io_addr, io_wdata, io_rdata;
	logic [1:0]  rx, ridx;
	logic [15:0] lfsr;
	logic [3:0]  straps [6] = '{4'h9, 4'hf, 4'h1, 4'h2, 4'h8, 4'h6};
	int          n_fail, n_compared, n_req;

	// ---------------------------------------------
	// design, far side and clocks
	// ---------------------------------------------
	tib_expander_model xp (.lnk_clk(lnk_clk), .lnk_en(lnk_en), .lnk_dir(lnk_dir),
		.lnk_data_in(lnk_data_in), .lnk_slot(lnk_slot), .lnk_data_out(lnk_data_out),
		.lnk_data_oe(lnk_data_oe));
	tib_bridge i_dut (.clk(clk), .reset(reset), .lnk_clk(lnk_clk), .lnk_en(lnk_en),
		.lnk_dir(lnk_dir), .lnk_data_in(lnk_data_in), .lnk_data_out(lnk_data_out),
		.lnk_data_oe(lnk_data_oe), .lnk_slot(lnk_slot), .chassis_address_strap(strap),
		.replica_index(ridx), .io_req(io_req), .io_wr(io_wr), .io_slot(io_slot),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
		.replica_share_link_tx(tx), .replica_share_link_rx(rx));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// counts cycles with an access open
	always @(negedge clk)
		if (io_req === 1'b1)
			n_req++;

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rsp(input tib_rsp_t got, input tib_rsp_t exp, input logic [31:0] m);
		n_compared++;
		if ((got & m) !== (exp & m))
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_rsp

	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// peer frame: start, 8 bits lsb first, stop, 4 cycles a bit
	task automatic peer(input int p, input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk) rx[p] <= f[i];
			repeat (3) @(posedge clk);
		end
	endtask : peer

	// own share frame sampled mid bit
	task automatic tx_grab(output logic [7:0] b);
		int k;
		k = 0;
		b = 8'h00;
		while (tx !== 1'b0 && k < 300)
		begin
			@(negedge clk);
			k++;
		end
		repeat (5) @(negedge clk);
		for (int i = 0; i < 8; i++)
		begin
			b[i] = tx;
			repeat (4) @(negedge clk);
		end
	endtask : tx_grab

	// i/o module side and peers for one access
	task automatic io_side(input tib_cmd_t c, input logic [3:0] s, input logic ack_it,
		input logic [7:0] own, input logic [1:0] pr, input logic [7:0] b0, b1,
		output logic [7:0] txb);
		int k;
		k = 0;
		txb = 8'h00;
		while (io_req !== 1'b1 && k < 400)
		begin
			@(negedge clk);
			k++;
		end
		chk({io_wr, io_slot, io_addr, io_wdata}, {c.wr, s, c.addr, c.wdata});
		if (ack_it)
		begin
			repeat (3) @(posedge clk);
			io_rdata <= own;
			io_ack <= 1'b1;
			@(posedge clk) io_ack <= 1'b0;
			io_rdata <= ~own;
		end
		while (io_req === 1'b1 && k < 700)
		begin
			@(negedge clk);
			k++;
		end
		if (!c.wr)
			fork
				if (pr[0]) peer(0, b0);
				if (pr[1]) peer(1, b1);
				tx_grab(txb);
			join
	endtask : io_side

	// ---------------------------------------------
	// one full command and response
	// ---------------------------------------------
	task automatic xfer(input logic wr, input logic ack_it, input logic [1:0] pr);
		tib_cmd_t   c;
		tib_rsp_t   got, exp;
		logic [3:0] s;
		logic [7:0] own, b0, b1, txb, ox;
		logic [7:0] d [3];
		logic [7:0] m [3];
		int         nb, o;
		c.chassis_id = strap;
		c.wr = wr;
		c.addr = rnd();
		c.wdata = rnd();
		s = 4'(rnd());
		own = rnd();
		b0 = rnd();
		b1 = rnd();
		fork
			begin
				xp.send_cmd(c, s);
				xp.get_rsp(200, got, nb);
			end
			io_side(c, s, ack_it, own, pr, b0, b1, txb);
		join
		// data set of replica k sits in place k, index 3 counts as 0
		ox = ack_it ? own : 8'h00;
		o = (ridx == 2'd3) ? 0 : int'(ridx);
		d[o] = wr ? 8'h00 : ox;
		d[(o + 1) % 3] = wr ? 8'h00 : b0;
		d[(o + 2) % 3] = wr ? 8'h00 : b1;
		m[o] = 8'hff;
		m[(o + 1) % 3] = {8{wr | pr[0]}};
		m[(o + 2) % 3] = {8{wr | pr[1]}};
		exp.diag = {strap, 1'b0, ~pr[1] & ~wr, ~pr[0] & ~wr, ~ack_it};
		exp.data_a = d[0];
		exp.data_b = d[1];
		exp.data_c = d[2];
		chk(nb, 32);
		chk_rsp(got, exp, {8'hff, m[0], m[1], m[2]});
		if (!wr)
			chk(txb, ox);
	endtask : xfer

	// packet for another chassis or a bad strap setting
	task automatic refused(input logic [3:0] id);
		tib_cmd_t c;
		tib_rsp_t got;
		int       nb, n0;
		c.chassis_id = id;
		c.wr = 1'b0;
		c.addr = rnd();
		c.wdata = rnd();
		n0 = n_req;
		xp.send_cmd(c, 4'h3);
		xp.get_rsp(20, got, nb);
		chk(nb, 0);
		chk(n_req, n0);
	endtask : refused

	// ---------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------
	initial
	begin
		reset = 1'b1;
		io_ack = 1'b0;
		io_rdata = 8'h00;
		rx = 2'b11;
		ridx = 2'h1;
		strap = 4'h6;
		lfsr = 16'h0061;
		n_fail = 0;
		n_compared = 0;
		n_req = 0;
		repeat (6) xp.tick();
		@(posedge clk) reset <= 1'b0;
		repeat (6) xp.tick();
		foreach (straps[i])
		begin
			@(posedge clk) strap <= straps[i];
			repeat (4) xp.tick();
			if (strap inside {[4'h2:4'h8]})
			begin
				xfer(1'b0, 1'b1, 2'b11);
				xfer(1'b1, 1'b1, 2'b00);
				refused(~strap);
			end
			else
				refused(strap);
		end
		xfer(1'b0, 1'b1, 2'b01);
		xfer(1'b0, 1'b1, 2'b10);
		xfer(1'b1, 1'b0, 2'b00);
		xfer(1'b0, 1'b0, 2'b11);
		for (int i = 0; i < 6; i++)
		begin
			void'(rnd());
			@(posedge clk) ridx <= 2'(i);
			repeat (4) xp.tick();
			xfer(lfsr[3], 1'b1, lfsr[5:4]);
		end
		end_of_test();
	end

	initial
	begin
		#300000;
		n_fail++;
		end_of_test();
	end
endmodule : tb_tib_bridge
`default_nettype wire
